// *** rtl/amsf_top.sv ***
// Per-axis status flag words, position and pulse input counting
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Activity flag high from operation start until that operation ends, except for pulser operation.
// - Output-complete set when positioning, jog or pulser operation finishes.
// - Output-complete also set when a decelerating or forced stop finishes.
// - Output-complete cleared when any next operation starts.
// - At most one speed-phase flag shows the current profile zone.
// - Homing-complete set on homing finish, cleared on next start.
// - Direction flag holds the direction of the last output pulse while busy, low when idle.
// - Home flag mirrors the valid home input.
// - Near-home flag mirrors the valid near-home input.
// - Compare flag high when position is at or above comparison count.
// - Confirm flag set on positioning start, cleared on parameter memory write.
// - Positive and negative limit inputs mirrored onto two flags.
// - Timing input mirrored onto the timing monitor flag.
// - Setpoint-error flag set when an invalid set value is seen.
// - Limit-error set when a limit is active during or at start of any operation except pulser operation.
// - Each axis owns one 16-flag word at successive 16-flag steps.
// - Pulse input serves pulser operation or feedback counting, never both.
// - Pulse input decoded as quadrature, pulse plus direction, or up/down.
module amsf_top #(
    parameter int unsigned NAXES = amsf_pkg::AXES,
    parameter int unsigned POS_W = amsf_pkg::POS_W
) (
    input  wire logic                 CLK_I,
    input  wire logic                 SRST_I,
    input  wire logic [NAXES-1:0]     OP_START_I,
    input  wire logic [NAXES*3-1:0]   OP_KIND_I,
    input  wire logic [NAXES-1:0]     OP_DONE_I,
    input  wire logic [NAXES-1:0]     STOP_DONE_I,
    input  wire logic [NAXES*2-1:0]   PHASE_I,
    input  wire logic [NAXES-1:0]     OUT_PULSE_I,
    input  wire logic [NAXES-1:0]     OUT_UP_I,
    input  wire logic [NAXES*POS_W-1:0] CMP_VALUE_I,
    input  wire logic [NAXES-1:0]     SETPOINT_INVALID_I,
    input  wire logic [NAXES-1:0]     ERROR_CLEAR_I,
    input  wire logic                 PARAM_WRITE_I,
    input  wire logic [NAXES-1:0]     PULSER_ENABLE_I,
    input  wire logic [NAXES*2-1:0]   PULSE_METHOD_I,
    input  wire logic [NAXES*2-1:0]   PULSE_MULT_I,
    input  wire logic [NAXES-1:0]     HOME_I,
    input  wire logic [NAXES-1:0]     NEAR_HOME_I,
    input  wire logic [NAXES-1:0]     POS_LIMIT_I,
    input  wire logic [NAXES-1:0]     NEG_LIMIT_I,
    input  wire logic [NAXES-1:0]     TIMING_I,
    input  wire logic [NAXES-1:0]     PULSE_A_I,
    input  wire logic [NAXES-1:0]     PULSE_B_I,
    output logic [NAXES*16-1:0]       STATUS_O,
    output logic [NAXES*POS_W-1:0]    POSITION_O,
    output logic [NAXES*POS_W-1:0]    FEEDBACK_O,
    output logic [NAXES-1:0]          PULSER_STEP_O,
    output logic [NAXES-1:0]          PULSER_UP_O
);
    // ------------------------------------------------------------
    // Pin synchronisers and pulse input decoders
    // ------------------------------------------------------------
    localparam int unsigned SW = NAXES * amsf_pkg::SYNC_NPIN;

    logic [SW-1:0]    pins_sync;
    logic [NAXES-1:0] home_s;
    logic [NAXES-1:0] near_s;
    logic [NAXES-1:0] plim_s;
    logic [NAXES-1:0] nlim_s;
    logic [NAXES-1:0] tim_s;
    logic [NAXES-1:0] pa_s;
    logic [NAXES-1:0] pb_s;
    logic [NAXES-1:0] qd_step;
    logic [NAXES-1:0] qd_up;

    amsf_sync #(.WIDTH(SW)) u_sync (
        .clk_i  (CLK_I),
        .srst_i (SRST_I),
        .d_i    ({PULSE_B_I, PULSE_A_I, TIMING_I, NEG_LIMIT_I,
                  POS_LIMIT_I, NEAR_HOME_I, HOME_I}),
        .q_o    (pins_sync)
    );

    assign {pb_s, pa_s, tim_s, nlim_s, plim_s, near_s, home_s} = pins_sync;

    genvar g;
    generate
        for (g = 0; g < NAXES; g++) begin : gen_pdecode
            amsf_pulse_decoder u_pdecode (
                .clk_i    (CLK_I),
                .srst_i   (SRST_I),
                .a_i      (pa_s[g]),
                .b_i      (pb_s[g]),
                .method_i (PULSE_METHOD_I[g*2 +: 2]),
                .mult_i   (PULSE_MULT_I[g*2 +: 2]),
                .step_o   (qd_step[g]),
                .up_o     (qd_up[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Per-axis state
    // ------------------------------------------------------------
    logic [15:0]               status      [NAXES];
    logic [15:0]               next_status [NAXES];
    amsf_pkg::amsf_state_type  state       [NAXES];
    amsf_pkg::amsf_state_type  next_state  [NAXES];
    amsf_pkg::amsf_kind_type   kind        [NAXES];
    amsf_pkg::amsf_kind_type   next_kind   [NAXES];
    logic [POS_W-1:0]          pos         [NAXES];
    logic [POS_W-1:0]          next_pos    [NAXES];
    logic [POS_W-1:0]          fb          [NAXES];
    logic [POS_W-1:0]          next_fb     [NAXES];
    logic [NAXES-1:0]          pstep;
    logic [NAXES-1:0]          next_pstep;
    logic [NAXES-1:0]          pup;
    logic [NAXES-1:0]          next_pup;

    always_comb begin
        amsf_pkg::amsf_kind_type k;
        logic                    fin;
        logic                    go;
        logic                    busy;
        k    = amsf_pkg::KIND_SINGLE;
        fin  = 1'b0;
        go   = 1'b0;
        busy = 1'b0;
        for (int i = 0; i < NAXES; i++) begin
            k    = amsf_pkg::amsf_kind_type'(OP_KIND_I[i*3 +: 3]);
            fin  = OP_DONE_I[i] && (state[i] == amsf_pkg::ST_RUN);
            go   = OP_START_I[i];
            next_status[i] = status[i];
            next_kind[i]   = go ? k : kind[i];
            case (state[i])
                amsf_pkg::ST_IDLE: next_state[i] = go ? amsf_pkg::ST_RUN
                                                      : amsf_pkg::ST_IDLE;
                amsf_pkg::ST_RUN: begin
                    if (go)
                        next_state[i] = amsf_pkg::ST_RUN;
                    else if (fin || STOP_DONE_I[i])
                        next_state[i] = amsf_pkg::ST_IDLE;
                    else
                        next_state[i] = amsf_pkg::ST_RUN;
                end
                default: next_state[i] = amsf_pkg::ST_IDLE;
            endcase
            // Pulser operation runs but outputs no own profile
            busy = (next_state[i] == amsf_pkg::ST_RUN)
                && (next_kind[i] != amsf_pkg::KIND_PULSER);
            next_status[i][amsf_pkg::F_BUSY] = busy;
            // Set wins over the clear raised by a simultaneous start
            next_status[i][amsf_pkg::F_DONE] =
                (fin && kind[i] != amsf_pkg::KIND_HOMING)
                || STOP_DONE_I[i]
                || (status[i][amsf_pkg::F_DONE] && !go);
            next_status[i][amsf_pkg::F_HOMED] =
                (fin && kind[i] == amsf_pkg::KIND_HOMING)
                || (status[i][amsf_pkg::F_HOMED] && !go);
            next_status[i][amsf_pkg::F_ACCEL]  = 1'b0;
            next_status[i][amsf_pkg::F_CRUISE] = 1'b0;
            next_status[i][amsf_pkg::F_DECEL]  = 1'b0;
            if (busy) begin
                case (amsf_pkg::amsf_phase_type'(PHASE_I[i*2 +: 2]))
                    amsf_pkg::PH_ACCEL:  next_status[i][amsf_pkg::F_ACCEL]  = 1'b1;
                    amsf_pkg::PH_CRUISE: next_status[i][amsf_pkg::F_CRUISE] = 1'b1;
                    amsf_pkg::PH_DECEL:  next_status[i][amsf_pkg::F_DECEL]  = 1'b1;
                    default:             next_status[i][amsf_pkg::F_ACCEL]  = 1'b0;
                endcase
            end
            if (!busy)
                next_status[i][amsf_pkg::F_DIR] = 1'b0;
            else if (OUT_PULSE_I[i])
                next_status[i][amsf_pkg::F_DIR] = OUT_UP_I[i];
            next_status[i][amsf_pkg::F_HOME]   = home_s[i];
            next_status[i][amsf_pkg::F_NEAR]   = near_s[i];
            next_status[i][amsf_pkg::F_CMP]    = $signed(pos[i])
                >= $signed(CMP_VALUE_I[i*POS_W +: POS_W]);
            next_status[i][amsf_pkg::F_CONFIRM] =
                (go && (k == amsf_pkg::KIND_SINGLE || k == amsf_pkg::KIND_MULTI))
                || (status[i][amsf_pkg::F_CONFIRM] && !PARAM_WRITE_I);
            next_status[i][amsf_pkg::F_PLIM]   = plim_s[i];
            next_status[i][amsf_pkg::F_NLIM]   = nlim_s[i];
            next_status[i][amsf_pkg::F_TIMING] = tim_s[i];
            next_status[i][amsf_pkg::F_SETERR] = SETPOINT_INVALID_I[i]
                || (status[i][amsf_pkg::F_SETERR] && !ERROR_CLEAR_I[i]);
            next_status[i][amsf_pkg::F_LIMERR] =
                ((plim_s[i] || nlim_s[i]) && (status[i][amsf_pkg::F_BUSY] || busy))
                || (status[i][amsf_pkg::F_LIMERR] && !ERROR_CLEAR_I[i]);
            next_pos[i] = pos[i];
            if (OUT_PULSE_I[i])
                next_pos[i] = OUT_UP_I[i] ? pos[i] + 1'b1 : pos[i] - 1'b1;
            // The shared input is steered to one consumer only
            next_pstep[i] = qd_step[i] && PULSER_ENABLE_I[i];
            next_pup[i]   = qd_up[i];
            next_fb[i]    = fb[i];
            if (qd_step[i] && !PULSER_ENABLE_I[i])
                next_fb[i] = qd_up[i] ? fb[i] + 1'b1 : fb[i] - 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        for (int i = 0; i < NAXES; i++) begin
            if (SRST_I) begin
                status[i] <= amsf_pkg::STATUS_RESET;
                state[i]  <= amsf_pkg::ST_IDLE;
                kind[i]   <= amsf_pkg::KIND_SINGLE;
                pos[i]    <= POS_W'(amsf_pkg::POS_RESET);
                fb[i]     <= POS_W'(amsf_pkg::POS_RESET);
                pstep[i]  <= 1'b0;
                pup[i]    <= 1'b0;
            end else begin
                status[i] <= next_status[i];
                state[i]  <= next_state[i];
                kind[i]   <= next_kind[i];
                pos[i]    <= next_pos[i];
                fb[i]     <= next_fb[i];
                pstep[i]  <= next_pstep[i];
                pup[i]    <= next_pup[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Output packing: axis n word at bits n*16
    // ------------------------------------------------------------
    generate
        for (g = 0; g < NAXES; g++) begin : gen_out
            assign STATUS_O[g*16 +: 16]        = status[g];
            assign POSITION_O[g*POS_W +: POS_W] = pos[g];
            assign FEEDBACK_O[g*POS_W +: POS_W] = fb[g];
        end
    endgenerate
    assign PULSER_STEP_O = pstep;
    assign PULSER_UP_O   = pup;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    generate
        for (g = 0; g < NAXES; g++) begin : gen_chk
            AST_BUSY_SET: assert property (OP_START_I[g]
                && OP_KIND_I[g*3 +: 3] != amsf_pkg::KIND_PULSER
                |=> STATUS_O[g*16 + amsf_pkg::F_BUSY])
                else $error("activity flag not raised on start");
            AST_DONE_SET: assert property (OP_DONE_I[g]
                && STATUS_O[g*16 + amsf_pkg::F_BUSY] && !OP_START_I[g]
                && kind[g] != amsf_pkg::KIND_HOMING
                |=> STATUS_O[g*16 + amsf_pkg::F_DONE]
                && !STATUS_O[g*16 + amsf_pkg::F_BUSY])
                else $error("completion not flagged");
            AST_STOP_DONE: assert property (STOP_DONE_I[g]
                |=> STATUS_O[g*16 + amsf_pkg::F_DONE])
                else $error("stop completion not flagged");
            AST_DONE_CLR: assert property (OP_START_I[g] && !OP_DONE_I[g]
                && !STOP_DONE_I[g]
                |=> !STATUS_O[g*16 + amsf_pkg::F_DONE]
                && !STATUS_O[g*16 + amsf_pkg::F_HOMED])
                else $error("completion flags not cleared on start");
            AST_PHASE_ONE: assert property ($onehot0(
                STATUS_O[g*16 + amsf_pkg::F_ACCEL +: 3])
                && (STATUS_O[g*16 + amsf_pkg::F_BUSY]
                    || STATUS_O[g*16 + amsf_pkg::F_ACCEL +: 3] == 3'h0))
                else $error("speed phase flags not exclusive");
            AST_HOMED: assert property (OP_DONE_I[g] && !OP_START_I[g]
                && state[g] == amsf_pkg::ST_RUN
                && kind[g] == amsf_pkg::KIND_HOMING
                |=> STATUS_O[g*16 + amsf_pkg::F_HOMED]
                && !STATUS_O[g*16 + amsf_pkg::F_DONE])
                else $error("homing completion wrong");
            AST_DIR: assert property (STATUS_O[g*16 + amsf_pkg::F_DIR]
                |-> STATUS_O[g*16 + amsf_pkg::F_BUSY])
                else $error("direction high while idle");
            AST_HOME_MIRROR: assert property (##3
                STATUS_O[g*16 + amsf_pkg::F_HOME] == $past(HOME_I[g], 3)
                && STATUS_O[g*16 + amsf_pkg::F_NEAR]
                == $past(NEAR_HOME_I[g], 3))
                else $error("home or near-home flag does not follow pin");
            AST_CMP: assert property (##1 STATUS_O[g*16 + amsf_pkg::F_CMP]
                == ($signed($past(POSITION_O[g*POS_W +: POS_W]))
                >= $signed($past(CMP_VALUE_I[g*POS_W +: POS_W]))))
                else $error("compare flag wrong");
            AST_CONFIRM_CLR: assert property (PARAM_WRITE_I && !OP_START_I[g]
                |=> !STATUS_O[g*16 + amsf_pkg::F_CONFIRM])
                else $error("confirm flag not cleared by memory write");
            AST_LIMIT_ERR: assert property (plim_s[g]
                && STATUS_O[g*16 + amsf_pkg::F_BUSY]
                |=> STATUS_O[g*16 + amsf_pkg::F_LIMERR])
                else $error("limit error not raised");
            AST_SET_ERR: assert property (SETPOINT_INVALID_I[g]
                |=> STATUS_O[g*16 + amsf_pkg::F_SETERR])
                else $error("setpoint error not raised");
            AST_SHARED_INPUT: assert property (PULSER_STEP_O[g]
                |-> $stable(FEEDBACK_O[g*POS_W +: POS_W]))
                else $error("pulser step also counted as feedback");
            AST_RESET_CLEAR: assert property (@(posedge CLK_I) disable iff (1'b0)
                SRST_I |=> STATUS_O[g*16 +: 16] == 16'h0000)
                else $error("flags not cleared by reset");
            COV_HOMING: cover property (OP_DONE_I[g]
                && kind[g] == amsf_pkg::KIND_HOMING);
            COV_STOP: cover property (STOP_DONE_I[g]
                && STATUS_O[g*16 + amsf_pkg::F_DECEL]);
            COV_LIM_ERR: cover property (STATUS_O[g*16 + amsf_pkg::F_LIMERR]);
            COV_FB: cover property (!PULSER_ENABLE_I[g] && qd_step[g]);
        end
    endgenerate
endmodule
`default_nettype wire

// *** common/amsf_pkg.sv ***
// Shared constants and types for the axis motion status flag block
package amsf_pkg;
    localparam int unsigned AXES      = 4;
    localparam int unsigned POS_W     = 32;
    localparam int unsigned FLAG_W    = 16;
    localparam int unsigned SYNC_NPIN = 7;
    // Flag positions inside one axis status word
    localparam int unsigned F_BUSY    = 0;
    localparam int unsigned F_DONE    = 1;
    localparam int unsigned F_ACCEL   = 2;
    localparam int unsigned F_CRUISE  = 3;
    localparam int unsigned F_DECEL   = 4;
    localparam int unsigned F_DIR     = 5;
    localparam int unsigned F_HOME    = 6;
    localparam int unsigned F_NEAR    = 7;
    localparam int unsigned F_HOMED   = 8;
    localparam int unsigned F_CMP     = 9;
    localparam int unsigned F_CONFIRM = 10;
    localparam int unsigned F_PLIM    = 11;
    localparam int unsigned F_NLIM    = 12;
    localparam int unsigned F_TIMING  = 13;
    localparam int unsigned F_SETERR  = 14;
    localparam int unsigned F_LIMERR  = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [31:0] POS_RESET    = 32'h0000_0000;
    typedef enum logic [2:0] {
        KIND_SINGLE  = 3'b000,
        KIND_MULTI   = 3'b001,
        KIND_HOMING  = 3'b010,
        KIND_JOG     = 3'b011,
        KIND_JOG_POS = 3'b100,
        KIND_PULSER  = 3'b101
    } amsf_kind_type;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } amsf_state_type;
    typedef enum logic [1:0] {
        PH_NONE   = 2'b00,
        PH_ACCEL  = 2'b01,
        PH_CRUISE = 2'b10,
        PH_DECEL  = 2'b11
    } amsf_phase_type;
    localparam logic [1:0] METH_QUAD  = 2'h0;
    localparam logic [1:0] METH_DIR   = 2'h1;
    localparam logic [1:0] METH_UPDN  = 2'h2;
    localparam logic [1:0] MULT_X1    = 2'h0;
    localparam logic [1:0] MULT_X2    = 2'h1;
    localparam logic [1:0] MULT_X4    = 2'h2;
endpackage

// *** rtl/amsf_sync.sv ***
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module amsf_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_meta = d_i;
        next_q    = meta;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end
endmodule
`default_nettype wire

// *** rtl/amsf_pulse_decoder.sv ***
// Decoder for the two-phase pulse input pair of one axis
`timescale 1ns/10ps
`default_nettype none
module amsf_pulse_decoder (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       a_i,
    input  wire logic       b_i,
    input  wire logic [1:0] method_i,
    input  wire logic [1:0] mult_i,
    output logic            step_o,
    output logic            up_o
);
    logic a_prev;
    logic b_prev;
    logic edge_a;
    logic edge_b;
    logic rise_a;
    logic rise_b;

    always_comb begin
        edge_a = a_i ^ a_prev;
        edge_b = b_i ^ b_prev;
        rise_a = a_i & ~a_prev;
        rise_b = b_i & ~b_prev;
        step_o = 1'b0;
        up_o   = 1'b0;
        case (method_i)
            amsf_pkg::METH_QUAD: begin
                // Both phases moving at once is a glitch: never counted
                up_o = a_i ^ b_prev;
                case (mult_i)
                    amsf_pkg::MULT_X4: step_o = edge_a ^ edge_b;
                    amsf_pkg::MULT_X2: step_o = edge_a & ~edge_b;
                    default:           step_o = rise_a & ~edge_b;
                endcase
            end
            amsf_pkg::METH_DIR: begin
                step_o = rise_a;
                up_o   = ~b_i;
            end
            amsf_pkg::METH_UPDN: begin
                step_o = rise_a ^ rise_b;
                up_o   = rise_a;
            end
            default: begin
                step_o = 1'b0;
                up_o   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
        end else begin
            a_prev <= a_i;
            b_prev <= b_i;
        end
    end
endmodule
`default_nettype wire

// *** bench/amsf_enc_model.sv ***
// Stand-in for the pulser or encoder driving the two pulse input phases
`timescale 1ns/10ps
`default_nettype none
module amsf_enc_model (
    input  wire logic clk_i,
    output logic      a_o,
    output logic      b_o
);
    logic [1:0] q = 2'h0;
    initial begin
        a_o = 1'b0;
        b_o = 1'b0;
    end
    // One step per call; hold sets how slowly the edges come
    task automatic step(input logic up, input logic [1:0] m, input int hold);
        @(posedge clk_i);
        case (m)
            amsf_pkg::METH_QUAD: begin
                q = up ? q + 2'h1 : q - 2'h1;
                a_o <= q[1] ^ q[0];
                b_o <= q[1];
            end
            amsf_pkg::METH_DIR: begin
                b_o <= ~up;
                a_o <= 1'b1;
            end
            default: begin
                a_o <= up;
                b_o <= ~up;
            end
        endcase
        repeat (hold) @(posedge clk_i);
        if (m != amsf_pkg::METH_QUAD) begin
            a_o <= 1'b0;
            b_o <= (m == amsf_pkg::METH_DIR) ? ~up : 1'b0;
            repeat (hold) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// *** bench/amsf_top_bench.sv ***
// Self-checking bench for the axis status flag block
`timescale 1ns/10ps
`default_nettype none
module amsf_top_bench;
    logic         clk;
    logic         srst;
    logic         mem_wr;
    logic [3:0]   start, done, stopd, pulse, up, sinv, eclr, pen, home, near, plim, nlim, tim;
    logic [11:0]  kind;
    logic [7:0]   phase, meth, mult;
    logic [127:0] cmpv;
    wire          pa, pb;
    wire  [63:0]  status;
    wire  [127:0] posn, fb;
    wire  [3:0]   pstep, pup;
    int           mismatches = 0;
    int           n_checks = 0;
    int           nsteps = 0;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    amsf_top dut (
        .CLK_I(clk), .SRST_I(srst), .OP_START_I(start), .OP_KIND_I(kind),
        .OP_DONE_I(done), .STOP_DONE_I(stopd), .PHASE_I(phase), .OUT_PULSE_I(pulse),
        .OUT_UP_I(up), .CMP_VALUE_I(cmpv), .SETPOINT_INVALID_I(sinv),
        .ERROR_CLEAR_I(eclr), .PARAM_WRITE_I(mem_wr), .PULSER_ENABLE_I(pen),
        .PULSE_METHOD_I(meth), .PULSE_MULT_I(mult), .HOME_I(home), .NEAR_HOME_I(near),
        .POS_LIMIT_I(plim), .NEG_LIMIT_I(nlim), .TIMING_I(tim), .PULSE_A_I({4{pa}}),
        .PULSE_B_I({4{pb}}), .STATUS_O(status), .POSITION_O(posn), .FEEDBACK_O(fb),
        .PULSER_STEP_O(pstep), .PULSER_UP_O(pup)
    );
    amsf_enc_model mdl (.clk_i(clk), .a_o(pa), .b_o(pb));

    always @(posedge clk) begin
        if (pstep[3] === 1'b1 && pup[3] === 1'b1) nsteps++;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, s, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [31:0] w(input int a);
        return {16'h0, status[a*16 +: 16]};
    endfunction
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_run();
        @(posedge clk) cmpv[31:0] <= 32'h2;
        start[0] <= 1'b1;
        @(posedge clk) start[0] <= 1'b0;
        phase[1:0] <= 2'h1;
        #1 chk(w(0), 32'h0401, "start");
        tk(1);
        chk(w(0), 32'h0405, "accel");
        repeat (2) begin
            @(posedge clk) pulse[0] <= 1'b1;
            up[0] <= 1'b1;
            @(posedge clk) pulse[0] <= 1'b0;
        end
        phase[1:0] <= 2'h3;
        tk(2);
        chk(w(0), 32'h0631, "decel at compare");
        chk(posn[31:0], 32'h2, "position count");
        @(posedge clk) done[0] <= 1'b1;
        phase[1:0] <= 2'h0;
        @(posedge clk) done[0] <= 1'b0;
        #1 chk(w(0), 32'h0602, "finished");
        @(posedge clk) mem_wr <= 1'b1;
        @(posedge clk) mem_wr <= 1'b0;
        #1 chk(w(0), 32'h0202, "memory write");
        @(posedge clk) kind[2:0] <= 3'h1;
        start[0] <= 1'b1;
        @(posedge clk) start[0] <= 1'b0;
        #1 chk(w(0), 32'h0601, "multi-point start");
        $display("t_run finished");
    endtask

    task automatic t_home();
        @(posedge clk) kind[5:3] <= 3'h2;
        start[1] <= 1'b1;
        @(posedge clk) start[1] <= 1'b0;
        done[1] <= 1'b1;
        @(posedge clk) done[1] <= 1'b0;
        #1 chk(w(1) & 32'h0101, 32'h0100, "homed");
        chk(w(0), 32'h0601, "other axis untouched");
        for (int k = 3; k <= 5; k += 2) begin
            @(posedge clk) kind[5:3] <= 3'(k);
            start[1] <= 1'b1;
            @(posedge clk) start[1] <= 1'b0;
            #1 chk(w(1), (k == 3) ? 32'h1 : 32'h0, "next start");
            @(posedge clk) stopd[1] <= 1'b1;
            @(posedge clk) stopd[1] <= 1'b0;
            #1 chk(w(1), 32'h0002, "stop finished");
        end
        $display("t_home finished");
    endtask

    task automatic t_pins();
        @(posedge clk) kind[8:6] <= 3'h4;
        start[2] <= 1'b1;
        @(posedge clk) start[2] <= 1'b0;
        {home[2], near[2], plim[2], nlim[2], tim[2]} <= 5'h1F;
        tk(4);
        chk(w(2), 32'hB8C1, "pins while busy");
        @(posedge clk) {home[2], near[2], plim[2], nlim[2], tim[2]} <= 5'h00;
        stopd[2] <= 1'b1;
        sinv[2] <= 1'b1;
        @(posedge clk) stopd[2] <= 1'b0;
        sinv[2] <= 1'b0;
        tk(4);
        chk(w(2), 32'hC002, "errors held");
        @(posedge clk) eclr[2] <= 1'b1;
        @(posedge clk) eclr[2] <= 1'b0;
        plim[2] <= 1'b1;
        tk(4);
        chk(w(2), 32'h0802, "errors cleared, idle limit");
        @(posedge clk) start[2] <= 1'b1;
        @(posedge clk) start[2] <= 1'b0;
        #1 chk(w(2) & 32'h8000, 32'h8000, "limit at start");
        $display("t_pins finished");
    endtask

    task automatic t_pulse();
        @(posedge clk) meth <= 8'h55;
        pen[3] <= 1'b1;
        tk(4);
        repeat (3) mdl.step(1'b1, amsf_pkg::METH_DIR, 13);
        tk(4);
        chk(fb[31:0], 32'h3, "pulse plus direction");
        chk(fb[127:96], 32'h0, "pulser owns input");
        chk(nsteps, 32'h3, "pulser steps");
        @(posedge clk) meth <= 8'h00;
        mult <= 8'h06;
        pen[3] <= 1'b0;
        tk(4);
        repeat (4) mdl.step(1'b1, amsf_pkg::METH_QUAD, 26);
        tk(4);
        chk(fb[31:0], 32'h7, "quadrature x4");
        chk(fb[63:32], 32'h5, "quadrature x2");
        chk(fb[127:96], 32'h1, "feedback once pulser off");
        @(posedge clk) meth <= 8'hAA;
        tk(4);
        repeat (2) mdl.step(1'b0, amsf_pkg::METH_UPDN, 13);
        tk(4);
        chk(fb[31:0], 32'h5, "down pulses");
        $display("t_pulse finished");
    endtask

    initial begin
        srst = 1'b1;
        mem_wr = 1'b0;
        {start, done, stopd, pulse, up, sinv, eclr, pen} = 32'h0;
        {home, near, plim, nlim, tim} = 20'h0;
        {kind, phase, meth, mult} = 36'h0;
        cmpv = {4{32'h0000_0010}};
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        tk(1);
        chk(status[31:0], 32'h0, "reset low words");
        chk(status[63:32], 32'h0, "reset high words");
        t_run();
        t_home();
        t_pins();
        t_pulse();
        wrap_up();
    end

    // Far longer than the whole sequence needs
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
